/* File: pcc_ovf_detect.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------------
// cycle overflow detector
// ---------------------------------------------------------------------
module pcc_ovf_detect
  import pcc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  input  wire logic             ref_clk_i,  // system clock
  input  wire logic             rst_n_i,    // async reset, low
  input  wire logic [CNT_W-1:0] counter_i,  // main_array_counter value
  input  wire logic             tick_i,     // counter advances this cycle
  input  wire logic [1:0]       len_sel_i,  // cycle_length_select
  output logic                  ovf_o       // one-cycle overflow pulse
);

  typedef struct packed {
    logic ovf; // registered pulse
  } pcc_ovf_s;

  pcc_ovf_s st_ff;
  pcc_ovf_s nxt_st;

  // ---------------------------------------------------------------------
  // detect carry out of the selected bit
  // ---------------------------------------------------------------------
  // carry leaves bit n-1 when bits n-1..0 are all ones and the count steps
  always_comb begin
    logic [CNT_W-1:0] mask;
    mask = '0;
    case (len_sel_i)
      LEN_8:   mask = CNT_W'(16'h00ff);
      LEN_9:   mask = CNT_W'(16'h01ff);
      LEN_10:  mask = CNT_W'(16'h03ff);
      LEN_11:  mask = CNT_W'(16'h07ff);
      default: mask = CNT_W'(16'h00ff);
    endcase
    nxt_st.ovf = tick_i && ((counter_i & mask) == mask);
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign ovf_o = st_ff.ovf;

endmodule // pcc_ovf_detect

/* File: pcc_pkg.sv */
package pcc_pkg;

  // ---------------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADDR_PWM_CYCLE_CONFIG = 8'ha1; // config register
  localparam logic [7:0] RST_PWM_CYCLE_CONFIG  = 8'h00; // reset value
  localparam int         NUM_CH                = 3;     // channel count

  // compare high / low addresses per channel
  localparam logic [7:0] ADDR_CMP_LOW  [NUM_CH] = '{8'hfb, 8'he9, 8'heb};
  localparam logic [7:0] ADDR_CMP_HIGH [NUM_CH] = '{8'hfc, 8'hea, 8'hec};

  // ---------------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------------
  localparam int BIT_RELOAD_VIEW = 7; // reload_view_select
  localparam int BIT_OVF_IRQ_EN  = 6; // cycle_overflow_irq_enable
  localparam int BIT_OVF_FLAG    = 5; // cycle_overflow_flag
  localparam int BIT_LEN_MSB     = 1; // cycle_length_select msb
  localparam int BIT_LEN_LSB     = 0; // cycle_length_select lsb

  // ---------------------------------------------------------------------
  // cycle lengths
  // ---------------------------------------------------------------------
  localparam logic [1:0] LEN_8  = 2'h0;
  localparam logic [1:0] LEN_9  = 2'h1;
  localparam logic [1:0] LEN_10 = 2'h2;
  localparam logic [1:0] LEN_11 = 2'h3;
  localparam logic [4:0] BITS_BASE = 5'h08; // bits for code 00
  localparam logic [4:0] BITS_WIDE = 5'h10; // 16-bit pwm cycle

  // number of cycle bits for a length code
  function automatic logic [4:0] len_bits(input logic [1:0] code);
    len_bits = BITS_BASE + {3'h0, code};
  endfunction

endpackage

/* File: pcc_pwm_cycle_config.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------------
// pwm cycle length configuration and auto-reload register set
// ---------------------------------------------------------------------
module pcc_pwm_cycle_config
  import pcc_pkg::*;
#(
  parameter int NCH   = NUM_CH, // pwm channels
  parameter int CNT_W = 16      // main counter width
) (
  input  wire logic                  ref_clk_i,         // system clock
  input  wire logic                  rst_n_i,           // async reset, low
  // special function register port
  input  wire logic [7:0]            sfr_addr_i,        // register address
  input  wire logic                  sfr_wr_i,          // write strobe
  input  wire logic                  sfr_rd_i,          // read strobe
  input  wire logic [7:0]            sfr_wdata_i,       // write data
  output logic [7:0]                 sfr_rdata_o,       // read data, +1 cyc
  // normal capture/compare registers, outside this block
  input  wire logic [7:0]            cap_rdata_i,       // addressed byte
  output logic                       cap_wr_o,          // forwarded write
  output logic [7:0]                 cap_addr_o,        // forwarded address
  output logic [7:0]                 cap_wdata_o,       // forwarded data
  // counter and channel modes
  input  wire logic [CNT_W-1:0]      counter_i,         // main counter
  input  wire logic                  tick_i,            // counter steps
  input  wire logic [NCH-1:0]        pwm_mode_i,        // channel in pwm
  input  wire logic [NCH-1:0]        wide_pwm_select_i, // channel 16-bit
  // results
  output logic [NCH-1:0][4:0]        chan_bits_o,       // cycle bits used
  output logic [NCH-1:0]             reload_load_o,     // load reload now
  output logic [NCH-1:0][10:0]       reload_value_o,    // reload compare
  output logic                       cycle_overflow_o,  // overflow pulse
  output logic                       irq_o              // interrupt request
);

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  // every register of the block except the detector's sits in one struct, so reset and
  // update stay in a single pair of processes
  typedef struct packed {
    logic                  view;     // reload_view_select
    logic                  irq_en;   // cycle_overflow_irq_enable
    logic                  flag;     // cycle_overflow_flag
    logic [1:0]            len_sel;  // cycle_length_select
    logic [NCH-1:0][7:0]   rl_hi;    // reload high bytes
    logic [NCH-1:0][7:0]   rl_lo;    // reload low bytes
    logic [7:0]            rdata;    // read data
    logic                  cap_wr;   // forwarded write pulse
    logic [7:0]            cap_addr; // forwarded address
    logic [7:0]            cap_wdata;// forwarded data
    logic [NCH-1:0][4:0]   bits;     // per-channel cycle bits
    logic [NCH-1:0]        load;     // reload pulses
    logic [NCH-1:0][10:0]  rl_val;   // reload value out
    logic                  ovf;      // overflow pulse out
    logic                  irq;      // interrupt out
  } pcc_state_s;

  pcc_state_s st_ff;  // registered state
  pcc_state_s nxt_st; // next state

  logic hw_ovf; // overflow pulse from detector

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  // compare address decode, used for reads and writes
  function automatic logic [3:0] cmp_decode(input logic [7:0] addr);
    // {hit, high, channel[1:0]}
    // a miss leaves hit low; the channel field is then don't-care
    cmp_decode = 4'h0;
    for (int c = 0; c < NCH; c++) begin
      if (addr == ADDR_CMP_LOW[c]) begin
        cmp_decode = {2'b10, 2'(c)};
      end
      if (addr == ADDR_CMP_HIGH[c]) begin
        cmp_decode = {2'b11, 2'(c)};
      end
    end
  endfunction

  // config register image; unused bits always zero
  function automatic logic [7:0] cfg_image(input pcc_state_s s);
    cfg_image = 8'h00;
    cfg_image[BIT_RELOAD_VIEW] = s.view;
    cfg_image[BIT_OVF_IRQ_EN]  = s.irq_en;
    cfg_image[BIT_OVF_FLAG]    = s.flag;
    cfg_image[BIT_LEN_MSB:BIT_LEN_LSB] = s.len_sel;
  endfunction

  // ---------------------------------------------------------------------
  // overflow detector
  // ---------------------------------------------------------------------
  // the detector reads the registered length, so a new length takes
  // effect from the cycle after the config write
  pcc_ovf_detect #(
    .CNT_W (CNT_W)
  ) u_ovf (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .counter_i (counter_i),
    .tick_i    (tick_i),
    .len_sel_i (st_ff.len_sel),
    .ovf_o     (hw_ovf)
  );

  // ---------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------
  // one pass decides every field; the default holds the state and
  // drops the forwarded write pulse cap_wr
  always_comb begin
    logic [3:0]  dec;
    logic [1:0]  ch;
    logic        short_cyc;
    logic        cfg_wr;
    dec       = cmp_decode(sfr_addr_i);
    ch        = dec[1:0];
    short_cyc = 1'b0;
    cfg_wr    = sfr_wr_i && (sfr_addr_i == ADDR_PWM_CYCLE_CONFIG);
    nxt_st    = st_ff;
    nxt_st.cap_wr = 1'b0;

    // config write; unused bits simply dropped
    if (cfg_wr) begin
      nxt_st.view    = sfr_wdata_i[BIT_RELOAD_VIEW];
      nxt_st.irq_en  = sfr_wdata_i[BIT_OVF_IRQ_EN];
      nxt_st.len_sel = sfr_wdata_i[BIT_LEN_MSB:BIT_LEN_LSB];
      nxt_st.flag    = sfr_wdata_i[BIT_OVF_FLAG];
    end
    // hardware set beats a same-cycle software clear
    // the flag is never cleared here, only by the write above
    if (hw_ovf) begin
      nxt_st.flag = 1'b1;
    end

    // compare address writes: reload set or forwarded
    // the view in force before this edge picks the target, so a view
    // change and a compare write in one cycle cannot mix
    if (sfr_wr_i && dec[3]) begin
      if (st_ff.view) begin
        if (dec[2]) begin
          nxt_st.rl_hi[ch] = sfr_wdata_i;
        end else begin
          nxt_st.rl_lo[ch] = sfr_wdata_i;
        end
      end else begin
        nxt_st.cap_wr    = 1'b1;
        nxt_st.cap_addr  = sfr_addr_i;
        nxt_st.cap_wdata = sfr_wdata_i;
      end
    end

    // read data, latched one cycle after the strobe
    // reads change only the read data and the forwarded address; the flag is not cleared by a read
    if (sfr_rd_i) begin
      if (sfr_addr_i == ADDR_PWM_CYCLE_CONFIG) begin
        nxt_st.rdata = cfg_image(st_ff);
      end else if (dec[3] && st_ff.view) begin
        nxt_st.rdata = dec[2] ? st_ff.rl_hi[ch] : st_ff.rl_lo[ch];
      end else if (dec[3]) begin
        nxt_st.rdata = cap_rdata_i;
      end else begin
        nxt_st.rdata = 8'h00; // unmapped reads zero
      end
    end
    // forward the read address so the compare file can answer
    if (sfr_rd_i && dec[3] && !st_ff.view) begin
      nxt_st.cap_addr = sfr_addr_i;
    end

    // per-channel cycle length and reload handling
    // length is reported even for channels not in pwm mode
    short_cyc = (st_ff.len_sel != LEN_8);
    for (int c = 0; c < NCH; c++) begin
      if (wide_pwm_select_i[c]) begin
        nxt_st.bits[c] = BITS_WIDE;
      end else begin
        nxt_st.bits[c] = len_bits(st_ff.len_sel);
      end
      // reload only for 9..11 bit pwm; zero and idle otherwise
      // only 11 bits reach a channel: the upper high-byte bits are
      // stored for read-back but never used
      if (pwm_mode_i[c] && !wide_pwm_select_i[c] && short_cyc) begin
        nxt_st.rl_val[c] = {st_ff.rl_hi[c][2:0], st_ff.rl_lo[c]};
        nxt_st.load[c]   = hw_ovf;
      end else begin
        nxt_st.rl_val[c] = 11'h000;
        nxt_st.load[c]   = 1'b0;
      end
    end

    nxt_st.ovf = hw_ovf;
    // level request while flag and enable both stand
    // limitation: a level, not a pulse; it falls only when software
    // clears the flag or the enable
    nxt_st.irq = nxt_st.flag && nxt_st.irq_en;
  end

  // ---------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0; // matches the all-zero register reset
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  // nothing is decoded on the way out, so each pin sees one flop
  assign sfr_rdata_o      = st_ff.rdata;
  assign cap_wr_o         = st_ff.cap_wr;
  assign cap_addr_o       = st_ff.cap_addr;
  assign cap_wdata_o      = st_ff.cap_wdata;
  assign chan_bits_o      = st_ff.bits;
  assign reload_load_o    = st_ff.load;
  assign reload_value_o   = st_ff.rl_val;
  assign cycle_overflow_o = st_ff.ovf;
  assign irq_o            = st_ff.irq;

endmodule // pcc_pwm_cycle_config

/* File: pcc_pwm_cycle_config_bench.sv */
`timescale 1ns/10ps
module pcc_pwm_cycle_config_bench
  import pcc_pkg::*;
;
  // ---------------------------------------------------------------
  // design ports
  // ---------------------------------------------------------------
  logic                    ref_clk_i = 1'b0;
  logic                    rst_n_i = 1'b0;
  logic [7:0]              sfr_addr_i = 8'h00;
  logic                    sfr_wr_i = 1'b0;
  logic                    sfr_rd_i = 1'b0;
  logic [7:0]              sfr_wdata_i = 8'h00;
  logic [7:0]              cap_rdata_i = 8'h3c; // outside compare byte
  logic [15:0]             counter_i = 16'h0000;
  logic                    tick_i = 1'b0;
  logic [NUM_CH-1:0]       pwm_mode_i = 3'h1; // channel 0 in pwm
  logic [NUM_CH-1:0]       wide_pwm_select_i = 3'h2; // channel 1 wide
  logic [7:0]              sfr_rdata_o;
  logic                    cap_wr_o;
  logic [7:0]              cap_addr_o;
  logic [7:0]              cap_wdata_o;
  logic [NUM_CH-1:0][4:0]  chan_bits_o;
  logic [NUM_CH-1:0]       reload_load_o;
  logic [NUM_CH-1:0][10:0] reload_value_o;
  logic                    cycle_overflow_o;
  logic                    irq_o;
  logic [7:0]              d;         // last read byte
  int                      n_fail = 0;
  int                      samples_checked = 0;
  int                      n_ovf = 0;  // overflow pulses seen
  int                      n_load = 0; // channel 0 reload pulses seen

  pcc_pwm_cycle_config dut_u (
    .ref_clk_i         (ref_clk_i),
    .rst_n_i           (rst_n_i),
    .sfr_addr_i        (sfr_addr_i),
    .sfr_wr_i          (sfr_wr_i),
    .sfr_rd_i          (sfr_rd_i),
    .sfr_wdata_i       (sfr_wdata_i),
    .sfr_rdata_o       (sfr_rdata_o),
    .cap_rdata_i       (cap_rdata_i),
    .cap_wr_o          (cap_wr_o),
    .cap_addr_o        (cap_addr_o),
    .cap_wdata_o       (cap_wdata_o),
    .counter_i         (counter_i),
    .tick_i            (tick_i),
    .pwm_mode_i        (pwm_mode_i),
    .wide_pwm_select_i (wide_pwm_select_i),
    .chan_bits_o       (chan_bits_o),
    .reload_load_o     (reload_load_o),
    .reload_value_o    (reload_value_o),
    .cycle_overflow_o  (cycle_overflow_o),
    .irq_o             (irq_o)
  );

  // pulse counters, read on the falling edge where outputs are settled
  always @(negedge ref_clk_i) begin
    if (cycle_overflow_o === 1'b1) begin
      n_ovf++;
    end
    if (reload_load_o === 3'h1) begin
      n_load++;
    end
  end

  always #25 ref_clk_i = ~ref_clk_i;

  // ---------------------------------------------------------------
  // access tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge ref_clk_i);
    sfr_addr_i  <= a;
    sfr_wdata_i <= v;
    sfr_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    sfr_wr_i    <= 1'b0;
  endtask
  // data lands on the taking edge; sampled at the falling edge after it
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk_i);
    sfr_addr_i <= a;
    sfr_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    sfr_rd_i   <= 1'b0;
    @(negedge ref_clk_i);
    d = sfr_rdata_o;
  endtask
  // one counter step at value c, then idle past the flag latency
  task automatic ovf(input logic [15:0] c);
    @(posedge ref_clk_i);
    counter_i <= c;
    tick_i    <= 1'b1;
    @(posedge ref_clk_i);
    tick_i    <= 1'b0;
    counter_i <= 16'h0000;
    repeat (3) @(posedge ref_clk_i);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // guard against a hung sequence
  initial begin
    repeat (4000) @(posedge ref_clk_i);
    n_fail++;
    wrap_up;
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    rd(ADDR_PWM_CYCLE_CONFIG);
    chk("config reset", 16'(d), 16'(RST_PWM_CYCLE_CONFIG));
    wr(8'ha1, 8'hff);
    rd(8'ha1);
    chk("config rw", 16'(d), 16'h00e3);
    chk("irq soft set", 16'(irq_o), 16'h0001);
    wr(8'ha1, 8'h20);
    rd(8'ha1);
    chk("irq masked", 16'(irq_o), 16'h0000);
    chk("flag kept", 16'(d), 16'h0020);
    // every length code: one bit short, then the real wrap
    for (int c = 0; c < 4; c++) begin
      wr(8'ha1, 8'h40 | 8'(c));
      ovf(16'((32'h1 << (7 + c)) - 1));
      rd(8'ha1);
      chk("no wrap", 16'(d), 16'h0040 | 16'(c));
      ovf(16'((32'h1 << (8 + c)) - 1));
      rd(8'ha1);
      chk("wrap flag", 16'(d), 16'h0060 | 16'(c));
      chk("irq", 16'(irq_o), 16'h0001);
      chk("bits", 16'(chan_bits_o[0]), 16'h0008 + 16'(c));
      chk("wide bits", 16'(chan_bits_o[1]), 16'h0010);
      chk("ovf pulses", 16'(n_ovf), 16'(c + 1));
    end
    chk("reloads", 16'(n_load), 16'h0003);
    repeat (20) @(posedge ref_clk_i);
    rd(8'ha1);
    chk("sticky", 16'(d), 16'h0063);
    // reload view, 11-bit cycle
    wr(8'ha1, 8'h83);
    wr(ADDR_CMP_LOW[0], 8'h55);
    @(negedge ref_clk_i);
    chk("reload not fwd", 16'(cap_wr_o), 16'h0000);
    wr(ADDR_CMP_HIGH[0], 8'h07);
    rd(ADDR_CMP_LOW[0]);
    chk("reload low", 16'(d), 16'h0055);
    @(posedge ref_clk_i);
    pwm_mode_i <= 3'h3;
    ovf(16'h07ff);
    chk("reload value", 16'(reload_value_o[0]), 16'h0755);
    chk("wide reload", 16'(reload_value_o[1]), 16'h0000);
    chk("reload pulse", 16'(n_load), 16'h0004);
    // normal view goes to the outside registers
    wr(8'ha1, 8'h03);
    wr(ADDR_CMP_HIGH[1], 8'h12);
    @(negedge ref_clk_i);
    chk("fwd strobe", 16'(cap_wr_o), 16'h0001);
    chk("fwd addr", 16'(cap_addr_o), 16'(ADDR_CMP_HIGH[1]));
    chk("fwd data", 16'(cap_wdata_o), 16'h0012);
    rd(ADDR_CMP_HIGH[1]);
    chk("normal view", 16'(d), 16'h003c);
    rd(8'h00);
    chk("unmapped", 16'(d), 16'h0000);
    wrap_up;
  end
endmodule // pcc_pwm_cycle_config_bench

/* File: pcc_pwm_cycle_config_sva.sv */
`timescale 1ns/10ps
// ---------------------------------------------------------------------
// port checker for the cycle config block
// ---------------------------------------------------------------------
module pcc_pwm_cycle_config_sva
  import pcc_pkg::*;
#(
  parameter int NCH   = NUM_CH,
  parameter int CNT_W = 16
) (
  input wire logic             ref_clk_i,
  input wire logic             rst_n_i,
  input wire logic [7:0]       sfr_addr_i,
  input wire logic             sfr_wr_i,
  input wire logic             sfr_rd_i,
  input wire logic [7:0]       sfr_wdata_i,
  input wire logic [7:0]       sfr_rdata_o,
  input wire logic             cap_wr_o,
  input wire logic [7:0]       cap_addr_o,
  input wire logic [7:0]       cap_wdata_o,
  input wire logic [CNT_W-1:0] counter_i,
  input wire logic             tick_i,
  input wire logic [NCH-1:0]   wide_pwm_select_i,
  input wire logic [NCH-1:0][4:0] chan_bits_o,
  input wire logic [NCH-1:0]   reload_load_o,
  input wire logic             cycle_overflow_o,
  input wire logic             irq_o
);
  // shadow of the view, enable and length config fields, kept from observed writes
  logic [1:0] len_sh;
  logic       ie_sh;
  logic       view_sh;
  wire cfg_wr  = sfr_wr_i && sfr_addr_i == ADDR_PWM_CYCLE_CONFIG;
  wire cmp_hit = sfr_addr_i inside {ADDR_CMP_LOW, ADDR_CMP_HIGH};
  // low counter bits that form the selected cycle
  wire [CNT_W-1:0] len_mask = (CNT_W'(1) << (5'h08 + {3'h0, len_sh}))
                              - CNT_W'(1);
  wire lo_ones = &(counter_i | ~len_mask);
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {view_sh, ie_sh, len_sh} <= 4'h0;
    end else if (cfg_wr) begin
      {view_sh, ie_sh, len_sh} <= {sfr_wdata_i[7:6], sfr_wdata_i[1:0]};
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // write to a compare address in a given view
  sequence s_cmp_wr(v);
    sfr_wr_i && cmp_hit && view_sh == v;
  endsequence
  // counter leaves the selected top bit, config untouched
  sequence s_wrap;
    tick_i && lo_ones && !cfg_wr;
  endsequence
  a_fwd_normal: assert property (s_cmp_wr(1'b0) |=> cap_wr_o
    && cap_addr_o == $past(sfr_addr_i)
    && cap_wdata_o == $past(sfr_wdata_i)) else $error("write not forwarded");
  a_reload_hidden: assert property (s_cmp_wr(1'b1) |=> !cap_wr_o)
    else $error("reload write leaked");
  a_unused_zero: assert property (sfr_rd_i && sfr_addr_i == 8'ha1
    |=> sfr_rdata_o[4:2] == 3'h0) else $error("unused bits not zero");
  a_ovf_bit: assert property (s_wrap |-> ##2 cycle_overflow_o)
    else $error("overflow missed");
  a_ovf_cause: assert property (cycle_overflow_o |-> $past(tick_i, 2))
    else $error("overflow without tick");
  a_irq_raise: assert property (cycle_overflow_o && ie_sh
    |-> ##[0:1] irq_o) else $error("irq not raised");
  a_irq_mask: assert property (!ie_sh && !$past(ie_sh) |-> !irq_o)
    else $error("masked irq raised");
  a_flag_sticky: assert property (irq_o && !cfg_wr && !$past(cfg_wr)
    |=> irq_o) else $error("flag cleared by hardware");
  a_len_bits: assert property ($past(rst_n_i) |-> chan_bits_o[0] ==
    ($past(wide_pwm_select_i[0]) ? BITS_WIDE : 5'h08 + {3'h0, $past(len_sh)}))
    else $error("cycle bits wrong");
  a_no_reload8: assert property (len_sh == 2'h0 && $past(len_sh) == 2'h0
    && $past(len_sh, 2) == 2'h0 |-> reload_load_o == '0)
    else $error("reload in 8-bit cycle");
endmodule // pcc_pwm_cycle_config_sva

bind pcc_pwm_cycle_config pcc_pwm_cycle_config_sva #(
  .NCH   (NCH),
  .CNT_W (CNT_W)
) sva_u (
  .ref_clk_i         (ref_clk_i),
  .rst_n_i           (rst_n_i),
  .sfr_addr_i        (sfr_addr_i),
  .sfr_wr_i          (sfr_wr_i),
  .sfr_rd_i          (sfr_rd_i),
  .sfr_wdata_i       (sfr_wdata_i),
  .sfr_rdata_o       (sfr_rdata_o),
  .cap_wr_o          (cap_wr_o),
  .cap_addr_o        (cap_addr_o),
  .cap_wdata_o       (cap_wdata_o),
  .counter_i         (counter_i),
  .tick_i            (tick_i),
  .wide_pwm_select_i (wide_pwm_select_i),
  .chan_bits_o       (chan_bits_o),
  .reload_load_o     (reload_load_o),
  .cycle_overflow_o  (cycle_overflow_o),
  .irq_o             (irq_o)
);
